// File: rbe_defines.svh
// Constants of the remote button encoder mode controller.
// Assumes a 50 MHz system clock; included by its bare name.
`ifndef RBE_DEFINES_SVH
`define RBE_DEFINES_SVH
`define RBE_CLOCK_HZ      50000000
`define RBE_ID_WIDTH      24
`define RBE_BAUD_0        2400
`define RBE_BAUD_1        9600
`define RBE_BAUD_2        19200
`define RBE_BAUD_3        28800
`define RBE_PACKET_BYTES  4
`define RBE_FRAME_BITS    10
`define RBE_BLINK_CYCLES  24'h2625a0
`define RBE_LFSR_SEED     24'h5a3c96
`define RBE_ID_RESET      24'h000000
`define RBE_MASK_RESET    8'h00
`endif

// File: rbe_pkg.sv
// Types of the remote button encoder mode controller.
// Assumes nothing beyond the constants header.
package rbe_pkg;
  typedef enum logic [5:0] {
    RBE_ST_BOOT  = 6'h01,
    RBE_ST_SLEEP = 6'h02,
    RBE_ST_GEN   = 6'h04,
    RBE_ST_MASK  = 6'h08,
    RBE_ST_SEND  = 6'h10,
    RBE_ST_CHECK = 6'h20
  } rbe_state_t;
endpackage

// File: rbe_uart_tx.sv
// Serial byte shifter: start bit, eight data bits LSB first, stop bit.
// Assumes the bit period in cycles is steady while a byte is shifted.
`timescale 1ns/1ps
`include "rbe_defines.svh"
module rbe_uart_tx (
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic [15:0] i_bit_cycles,
  input  wire logic        i_valid,
  input  wire logic [7:0]  i_data,
  output logic             o_ready,
  output logic             o_serial
);
  logic [9:0]  shift_q;
  logic [3:0]  bits_q;
  logic [15:0] timer_q;
  logic        busy_q;

  assign o_ready = ~busy_q;

  // ---------------------------------------------------------------
  // Shifter
  // ---------------------------------------------------------------
  // Frame loaded on accept, shifted once per bit period
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      shift_q  <= 10'h3ff;
      bits_q   <= 4'h0;
      timer_q  <= 16'h0000;
      busy_q   <= 1'b0;
      o_serial <= 1'b1; // Idle high
    end else if (!busy_q) begin
      o_serial <= 1'b1;
      if (i_valid) begin
        shift_q  <= {1'b1, i_data, 1'b0};
        bits_q   <= 4'(`RBE_FRAME_BITS);
        timer_q  <= 16'h0000;
        busy_q   <= 1'b1;
      end
    end else if (timer_q == 16'h0000) begin
      if (bits_q == 4'h0) begin
        busy_q   <= 1'b0;
        o_serial <= 1'b1;
      end else begin
        o_serial <= shift_q[0];
        shift_q  <= {1'b1, shift_q[9:1]};
        bits_q   <= bits_q - 4'h1;
        timer_q  <= i_bit_cycles - 16'h0001;
      end
    end else begin
      timer_q <= timer_q - 16'h0001;
    end
  end

endmodule // rbe_uart_tx

// File: rbe_mode_ctrl.sv
// Mode controller of the remote button encoder: boot, sleep, key setup, transmit.
// Assumes level inputs from buttons; identifier and mask registers are held in
// an always-powered domain, so only i_resetn from that domain clears them.
`timescale 1ns/1ps
`include "rbe_defines.svh"
module rbe_mode_ctrl (
  input  wire logic       i_clock,
  input  wire logic       i_resetn,
  input  wire logic       i_rate_select_lo,
  input  wire logic       i_rate_select_hi,
  input  wire logic       i_code_generate,
  input  wire logic       i_send_request,
  input  wire logic [7:0] i_button_inputs,
  output logic            o_setup_indicator,
  output logic            o_transmitter_power_control,
  output logic            o_serial_data,
  output logic [23:0]     o_secret_id,
  output logic [7:0]      o_authority_mask
);
  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  logic [11:0] sync1_q;
  logic [11:0] sync2_q;
  logic        gen_prev_q;
  logic        send_prev_q;

  // Two stages on every pin
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_q <= 12'h000;
      sync2_q <= 12'h000;
    end else begin
      sync1_q <= {i_rate_select_hi, i_rate_select_lo, i_code_generate, i_send_request, i_button_inputs};
      sync2_q <= sync1_q;
    end
  end

  wire       rate_hi_s = sync2_q[11];
  wire       rate_lo_s = sync2_q[10];
  wire       gen_s     = sync2_q[9];
  wire       send_s    = sync2_q[8];
  wire [7:0] buttons_s = sync2_q[7:0];

  // Edge history
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      gen_prev_q  <= 1'b0;
      send_prev_q <= 1'b0;
    end else begin
      gen_prev_q  <= gen_s;
      send_prev_q <= send_s;
    end
  end

  wire gen_rise  = gen_s & ~gen_prev_q;
  wire gen_fall  = ~gen_s & gen_prev_q;
  wire send_rise = send_s & ~send_prev_q;

  // ---------------------------------------------------------------
  // State and rate latch
  // ---------------------------------------------------------------
  rbe_pkg::rbe_state_t state_q;
  logic [1:0]          rate_q;
  logic [1:0]          byte_idx_q;
  logic                tx_valid;
  logic                tx_ready;
  logic [7:0]          tx_byte;
  logic [23:0]         pkt_id_q;
  logic [7:0]          pkt_data_q;
  logic [1:0]          boot_wait_q;
  logic                pkt_sent_q;

  // Bit period in cycles for a rate code
  function automatic logic [15:0] bit_cycles(input logic [1:0] code);
    case (code)
      2'h0:    bit_cycles = 16'(`RBE_CLOCK_HZ / `RBE_BAUD_0);
      2'h1:    bit_cycles = 16'(`RBE_CLOCK_HZ / `RBE_BAUD_1);
      2'h2:    bit_cycles = 16'(`RBE_CLOCK_HZ / `RBE_BAUD_2);
      default: bit_cycles = 16'(`RBE_CLOCK_HZ / `RBE_BAUD_3);
    endcase
  endfunction

  // Boot waits for synchronisers to fill, latches rate, then checks send
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      boot_wait_q <= 2'h0;
      rate_q      <= 2'h0;
    end else if (state_q == rbe_pkg::RBE_ST_BOOT) begin
      boot_wait_q <= boot_wait_q + 2'h1;
      if (boot_wait_q == 2'h2) begin
        rate_q <= {rate_hi_s, rate_lo_s};
      end
    end
  end

  wire pkt_done = (byte_idx_q == 2'(`RBE_PACKET_BYTES - 1)) && tx_ready && tx_valid;
  wire send_exit = (state_q == rbe_pkg::RBE_ST_SEND) && pkt_sent_q && tx_ready && !send_s; // Last frame out

  // Mode sequencing
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= rbe_pkg::RBE_ST_BOOT;
    end else begin
      case (state_q)
        rbe_pkg::RBE_ST_BOOT: begin
          if (boot_wait_q == 2'h2) begin
            state_q <= rbe_pkg::RBE_ST_CHECK;
          end
        end
        rbe_pkg::RBE_ST_CHECK: begin
          state_q <= send_s ? rbe_pkg::RBE_ST_SEND : rbe_pkg::RBE_ST_SLEEP;
        end
        rbe_pkg::RBE_ST_SLEEP: begin
          if (gen_rise) begin
            state_q <= rbe_pkg::RBE_ST_GEN;
          end else if (send_rise) begin
            state_q <= rbe_pkg::RBE_ST_SEND;
          end
        end
        rbe_pkg::RBE_ST_GEN: begin
          if (gen_fall) begin
            state_q <= rbe_pkg::RBE_ST_MASK;
          end
        end
        rbe_pkg::RBE_ST_MASK: begin
          if (gen_rise) begin
            state_q <= rbe_pkg::RBE_ST_SLEEP;
          end
        end
        rbe_pkg::RBE_ST_SEND: begin
          if (send_exit) begin
            state_q <= rbe_pkg::RBE_ST_SLEEP;
          end
        end
        default: state_q <= rbe_pkg::RBE_ST_SLEEP;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Key setup
  // ---------------------------------------------------------------
  logic [23:0] lfsr_q;
  logic [7:0]  mask_acc_q;
  logic [23:0] blink_q;
  logic        blink_on_q;

  // Free-running generator; its value is random relative to the button hold
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      lfsr_q <= `RBE_LFSR_SEED;
    end else begin
      lfsr_q <= {lfsr_q[22:0], lfsr_q[23] ^ lfsr_q[22] ^ lfsr_q[21] ^ lfsr_q[16]};
    end
  end

  // Identifier captured on generate release; retained across sleep and sends
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_secret_id <= `RBE_ID_RESET;
    end else if (state_q == rbe_pkg::RBE_ST_GEN && gen_fall) begin
      o_secret_id <= lfsr_q;
    end
  end

  // Buttons accumulate while awaiting the mask; stored on second rise
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      mask_acc_q       <= 8'h00;
      o_authority_mask <= `RBE_MASK_RESET;
    end else if (state_q == rbe_pkg::RBE_ST_GEN) begin
      mask_acc_q <= 8'h00;
    end else if (state_q == rbe_pkg::RBE_ST_MASK) begin
      mask_acc_q <= mask_acc_q | buttons_s;
      if (gen_rise) begin
        o_authority_mask <= mask_acc_q | buttons_s;
      end
    end
  end

  // Indicator: steady in generate, blinking while awaiting the mask
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      blink_q           <= 24'h000000;
      blink_on_q        <= 1'b0;
      o_setup_indicator <= 1'b0;
    end else if (state_q == rbe_pkg::RBE_ST_GEN) begin
      blink_q           <= 24'h000000;
      blink_on_q        <= 1'b0; // Mask wait opens dark, so the toggle shows at once
      o_setup_indicator <= ~gen_fall;
    end else if (state_q == rbe_pkg::RBE_ST_MASK && !gen_rise) begin
      if (blink_q == `RBE_BLINK_CYCLES - 24'h000001) begin
        blink_q    <= 24'h000000;
        blink_on_q <= ~blink_on_q;
      end else begin
        blink_q <= blink_q + 24'h000001;
      end
      o_setup_indicator <= blink_on_q;
    end else begin
      blink_q           <= 24'h000000;
      o_setup_indicator <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Transmit
  // ---------------------------------------------------------------
  // Power control tracks transmit mode
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_transmitter_power_control <= 1'b0;
    end else begin
      o_transmitter_power_control <= (state_q == rbe_pkg::RBE_ST_SEND) && !send_exit;
    end
  end

  // Packet snapshot at each packet start, byte index advance
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      byte_idx_q <= 2'h0;
      pkt_sent_q <= 1'b0;
      pkt_id_q   <= 24'h000000;
      pkt_data_q <= 8'h00;
    end else if (state_q != rbe_pkg::RBE_ST_SEND) begin
      byte_idx_q <= 2'h0;
      pkt_sent_q <= 1'b0;
      pkt_id_q   <= o_secret_id;
      pkt_data_q <= buttons_s & o_authority_mask;
    end else if (tx_valid && tx_ready) begin
      byte_idx_q <= byte_idx_q + 2'h1;
      pkt_sent_q <= pkt_done;
      if (pkt_done) begin
        pkt_id_q   <= o_secret_id;
        pkt_data_q <= buttons_s & o_authority_mask;
      end
    end
  end

  assign tx_valid = (state_q == rbe_pkg::RBE_ST_SEND) && !(pkt_sent_q && !send_s);
  assign tx_byte  = (byte_idx_q == 2'h0) ? pkt_id_q[23:16] :
                    (byte_idx_q == 2'h1) ? pkt_id_q[15:8]  :
                    (byte_idx_q == 2'h2) ? pkt_id_q[7:0]   : pkt_data_q;

  // Serial shifter at the latched rate
  rbe_uart_tx u_tx (
    .i_clock      (i_clock),
    .i_resetn     (i_resetn),
    .i_bit_cycles (bit_cycles(rate_q)),
    .i_valid      (tx_valid),
    .i_data       (tx_byte),
    .o_ready      (tx_ready),
    .o_serial     (o_serial_data)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_boot_check: assert property (@(posedge i_clock) disable iff (!i_resetn)
    state_q == rbe_pkg::RBE_ST_CHECK |=> state_q == (($past(send_s)) ? rbe_pkg::RBE_ST_SEND : rbe_pkg::RBE_ST_SLEEP))
    else $error("boot check went wrong way");
  chk_sleep_power: assert property (@(posedge i_clock) disable iff (!i_resetn)
    state_q == rbe_pkg::RBE_ST_SLEEP && $past(state_q) == rbe_pkg::RBE_ST_SLEEP |-> !o_transmitter_power_control)
    else $error("power on while asleep");
  chk_sleep_wake: assert property (@(posedge i_clock) disable iff (!i_resetn)
    state_q == rbe_pkg::RBE_ST_SLEEP && gen_rise |=> state_q == rbe_pkg::RBE_ST_GEN)
    else $error("no key setup on generate rise");
  chk_id_store: assert property (@(posedge i_clock) disable iff (!i_resetn)
    state_q == rbe_pkg::RBE_ST_GEN && gen_fall |=> o_secret_id == $past(lfsr_q) && state_q == rbe_pkg::RBE_ST_MASK)
    else $error("identifier not stored");
  chk_ind_gen: assert property (@(posedge i_clock) disable iff (!i_resetn)
    state_q == rbe_pkg::RBE_ST_GEN && gen_s |=> o_setup_indicator)
    else $error("indicator low in generate");
  chk_mask_store: assert property (@(posedge i_clock) disable iff (!i_resetn)
    state_q == rbe_pkg::RBE_ST_MASK && gen_rise |=> o_authority_mask == $past(mask_acc_q | buttons_s) && !o_setup_indicator)
    else $error("mask not stored");
  chk_pkt_masked: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (pkt_data_q & ~o_authority_mask) == 8'h00 || state_q != rbe_pkg::RBE_ST_SEND)
    else $error("unauthorised button sent");
  chk_send_power: assert property (@(posedge i_clock) disable iff (!i_resetn)
    state_q == rbe_pkg::RBE_ST_SEND && $past(state_q) == rbe_pkg::RBE_ST_SEND |-> o_transmitter_power_control)
    else $error("power off mid transmit");
  chk_send_hold: assert property (@(posedge i_clock) disable iff (!i_resetn)
    state_q == rbe_pkg::RBE_ST_SEND && !send_exit |=> state_q == rbe_pkg::RBE_ST_SEND)
    else $error("packet truncated");
  chk_ind_blink: assert property (@(posedge i_clock) disable iff (!i_resetn)
    state_q == rbe_pkg::RBE_ST_MASK && $past(state_q) == rbe_pkg::RBE_ST_GEN |-> !o_setup_indicator)
    else $error("indicator did not toggle on mask wait");
  chk_rate_fixed: assert property (@(posedge i_clock) disable iff (!i_resetn)
    state_q != rbe_pkg::RBE_ST_BOOT |=> $stable(rate_q))
    else $error("rate changed after boot");

  cov_key_setup: cover property (@(posedge i_clock) disable iff (!i_resetn)
    state_q == rbe_pkg::RBE_ST_MASK && gen_rise);
  cov_send_done: cover property (@(posedge i_clock) disable iff (!i_resetn)
    send_exit);
  cov_back_to_back: cover property (@(posedge i_clock) disable iff (!i_resetn)
    state_q == rbe_pkg::RBE_ST_SEND && pkt_done && send_s);
endmodule // rbe_mode_ctrl

// File: rbe_tx_model.sv
// Behavioural model of the transmitter fed by the encoder's serial line.
// Assumes one clock shared with the encoder and a fixed bit period in cycles.
`timescale 1ns/1ps
module rbe_tx_model #(
  parameter int BIT_CYC = 1736
) (
  input  wire logic       i_clock,
  input  wire logic       i_resetn,
  input  wire logic       i_power,
  input  wire logic       i_serial,
  output logic [7:0]      o_byte,
  output logic            o_valid,
  output logic            o_error
);
  // ------------------------------------------------------------
  // Frame receiver
  // ------------------------------------------------------------
  int         cnt;
  int         bitn;
  logic       busy;
  logic [7:0] sh;

  // Mid-bit sampling of start, eight data bits LSB first, stop
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      busy    <= 1'b0;
      cnt     <= 0;
      bitn    <= 0;
      sh      <= 8'h00;
      o_byte  <= 8'h00;
      o_valid <= 1'b0;
      o_error <= 1'b0;
    end else begin
      o_valid <= 1'b0;
      if (!busy) begin
        if (i_power && !i_serial) begin
          busy <= 1'b1;
          cnt  <= BIT_CYC / 2;
          bitn <= 0;
        end
      end else if (!i_power) begin
        busy    <= 1'b0; // Power cut inside a frame
        o_valid <= 1'b1;
        o_error <= 1'b1;
      end else if (cnt == 0) begin
        cnt <= BIT_CYC - 1;
        bitn <= bitn + 1;
        if (bitn == 0 && i_serial) begin
          busy <= 1'b0; // Start bit too short
          o_valid <= 1'b1;
          o_error <= 1'b1;
        end else if (bitn >= 1 && bitn <= 8) begin
          sh <= {i_serial, sh[7:1]};
        end else if (bitn == 9) begin
          busy    <= 1'b0;
          o_byte  <= sh;
          o_valid <= 1'b1;
          o_error <= !i_serial;
        end
      end else begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // rbe_tx_model

// File: tb_top.sv
// Self-checking bench of the encoder mode controller with a transmitter model.
// Assumes a 50 MHz clock and a rate latched at 28800 bps at power-up.
`timescale 1ns/1ps
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin n_errors++; $display("MISMATCH t=%0t %s", $time, m); end end
module tb_top;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int BIT_CYC = 50000000 / 28800;
  logic        i_clock;
  logic        i_resetn;
  logic        i_rate_select_lo;
  logic        i_rate_select_hi;
  logic        i_code_generate;
  logic        i_send_request;
  logic [7:0]  i_button_inputs;
  logic        o_setup_indicator;
  logic        o_transmitter_power_control;
  logic        o_serial_data;
  logic [23:0] o_secret_id;
  logic [7:0]  o_authority_mask;
  logic [7:0]  rx_byte;
  logic        rx_valid;
  logic        rx_error;
  logic [7:0]  exp_q[$];
  logic [7:0]  exp_mask;
  logic [7:0]  btn;
  logic [7:0]  got;
  logic [23:0] id1;
  int          n_errors;
  int          comparisons;
  int          cycles;
  int          seed;
  int          k;

  // ------------------------------------------------------------
  // Instances and clock
  // ------------------------------------------------------------
  rbe_mode_ctrl dut_u (.i_clock(i_clock), .i_resetn(i_resetn), .i_rate_select_lo(i_rate_select_lo),
    .i_rate_select_hi(i_rate_select_hi), .i_code_generate(i_code_generate), .i_send_request(i_send_request),
    .i_button_inputs(i_button_inputs), .o_setup_indicator(o_setup_indicator),
    .o_transmitter_power_control(o_transmitter_power_control), .o_serial_data(o_serial_data),
    .o_secret_id(o_secret_id), .o_authority_mask(o_authority_mask));
  rbe_tx_model #(.BIT_CYC(BIT_CYC)) tx_u (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_power(o_transmitter_power_control), .i_serial(o_serial_data), .o_byte(rx_byte), .o_valid(rx_valid),
    .o_error(rx_error));

  // Free-running clock
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Full key setup: hold generate, release, enter buttons, rise again
  task automatic key_setup(input int hold, input logic [7:0] b1, input logic [7:0] b2);
    tick(1);
    i_code_generate <= 1'b1;
    tick(6);
    i_send_request <= 1'b1;
    repeat (hold) begin
      tick(1);
      #1;
      `CHK(o_setup_indicator, 1'b1, "indicator not steady in setup")
      `CHK(o_transmitter_power_control, 1'b0, "send taken during setup")
    end
    tick(1);
    i_send_request  <= 1'b0;
    i_code_generate <= 1'b0;
    tick(10);
    i_button_inputs <= b1;
    #1;
    `CHK(o_setup_indicator, 1'b0, "indicator not toggled on mask wait")
    tick(5);
    i_button_inputs <= b2;
    tick(5);
    i_button_inputs <= 8'h00;
    tick(5);
    i_code_generate <= 1'b1;
    tick(8);
    #1;
    `CHK(o_authority_mask, b1 | b2, "authority mask")
    `CHK(o_setup_indicator, 1'b0, "indicator left on")
    tick(1);
    i_code_generate <= 1'b0;
    tick(4);
  endtask

  // ------------------------------------------------------------
  // Result watcher and timeout
  // ------------------------------------------------------------
  always @(posedge i_clock) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("MISMATCH t=%0t unexpected byte", $time);
      end else begin
        got = exp_q.pop_front();
        `CHK(rx_byte, got, "packet byte")
      end
      `CHK(rx_error, 1'b0, "frame error")
    end
  end

  // Hang guard
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 90000) begin
      n_errors++;
      $display("MISMATCH t=%0t run too long", $time);
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 97;
    n_errors = 0;
    comparisons = 0;
    cycles = 0;
    i_resetn = 1'b0;
    i_rate_select_lo = 1'b1;
    i_rate_select_hi = 1'b1;
    i_code_generate = 1'b0;
    i_send_request = 1'b1;
    i_button_inputs = 8'h00;
    tick(6);
    i_resetn <= 1'b1;
    // Send held through power-up goes straight to transmit
    tick(8);
    #1;
    `CHK(o_transmitter_power_control, 1'b1, "no direct send")
    tick(BIT_CYC / 2);
    #1;
    `CHK(o_serial_data, 1'b0, "no start bit")
    tick(1);
    i_resetn <= 1'b0;
    i_send_request <= 1'b0;
    tick(6);
    #1;
    `CHK(o_serial_data, 1'b1, "serial not idle in reset")
    `CHK(o_secret_id, 24'h000000, "identifier reset")
    tick(1);
    i_resetn <= 1'b1;
    tick(12);
    #1;
    `CHK(o_transmitter_power_control, 1'b0, "power on in sleep")
    `CHK(o_setup_indicator, 1'b0, "indicator on in sleep")
    tick(1);
    i_rate_select_lo <= 1'b0; // Late rate change must be ignored
    i_rate_select_hi <= 1'b0;
    btn = 8'($random(seed));
    exp_mask = 8'($random(seed));
    key_setup(20, btn | 8'h01, exp_mask);
    id1 = o_secret_id;
    `CHK(id1 !== 24'h000000, 1'b1, "identifier not stored")
    btn = 8'($random(seed));
    exp_mask = 8'($random(seed)) | 8'h10;
    key_setup(37, btn, exp_mask);
    exp_mask = exp_mask | btn;
    `CHK(o_secret_id !== id1, 1'b1, "identifier not re-randomized")
    // One packet, send dropped half way through
    btn = 8'($random(seed));
    exp_q.push_back(o_secret_id[23:16]);
    exp_q.push_back(o_secret_id[15:8]);
    exp_q.push_back(o_secret_id[7:0]);
    exp_q.push_back(btn & exp_mask);
    tick(1);
    i_button_inputs <= btn;
    tick(4);
    i_send_request <= 1'b1;
    tick(8);
    #1;
    `CHK(o_transmitter_power_control, 1'b1, "power not raised")
    tick(BIT_CYC * 20);
    i_send_request <= 1'b0;
    i_button_inputs <= ~btn;
    for (k = 0; k < BIT_CYC * 25 && o_transmitter_power_control === 1'b1; k++) begin
      tick(1);
      #1;
    end
    #1;
    `CHK(o_transmitter_power_control, 1'b0, "power never dropped")
    `CHK(exp_q.size() == 0, 1'b1, "packet truncated")
    tick(20);
    #1;
    `CHK(o_serial_data, 1'b1, "serial not idle after packet")
    print_verdict();
  end
endmodule // tb_top
